// ### core/caf_map.vh
// register offsets, field positions and frame-type codes for the acceptance filter
`ifndef CAF_MAP_VH
`define CAF_MAP_VH
`define CAF_ADDR_W        2
`define CAF_OFS_FIL_HI    2'h0
`define CAF_OFS_FIL_LO    2'h1
`define CAF_OFS_MSK_HI    2'h2
`define CAF_OFS_MSK_LO    2'h3
`define CAF_LO_FIELD_HI   7
`define CAF_LO_FIELD_LO   4
`define CAF_CMP_W         12
`define CAF_ID_W          11
`define CAF_NIB_ZERO      4'h0
`define CAF_BYTE_ZERO     8'h00
`define CAF_CMP_ZERO      12'h000
`define CAF_BIT_ZERO      1'h0
`define CAF_ID_ZERO       11'h000
`define CAF_KIND_DATA     2'h0
`define CAF_KIND_EXT      2'h1
`define CAF_KIND_OVLD     2'h2
`endif

// ### core/caf_filter.v
// acceptance filter, filter and mask registers, and frame-scope gating
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "caf_map.vh"

// Functional notes
// - standard frames, base protocol arbitration only
// - extended frames acknowledged, never stored
// - overload frames recognised, never generated
// - compare filter with identifier plus RTR
// - mask one needs equality, zero ignores
// - store only on full masked match
// - filter high holds filter bits 11..4
// - filter low holds bits 3..0 at 7..4
// - mask high holds mask bits 11..4
module caf_filter
(
   input  wire                     clock_i,
   input  wire                     rst_b_i,
   input  wire [`CAF_ADDR_W-1:0]   addr_i,
   input  wire [7:0]               wdata_i,
   input  wire                     wr_i,
   input  wire                     rd_i,
   output reg  [7:0]               rdata_o,
   input  wire                     frm_valid_i,
   input  wire [1:0]               frm_kind_i,
   input  wire [`CAF_ID_W-1:0]     frm_id_i,
   input  wire                     frm_rtr_i,
   input  wire                     frm_crc_ok_i,
   output wire                     ack_o,
   output wire                     ovld_req_o,
   output reg                      store_o,
   output reg  [`CAF_ID_W-1:0]     store_id_o,
   output reg                      store_rtr_o,
   output reg                      discard_o,
   output reg                      match_q_o
);

   // filter and mask storage; low halves keep only their upper nibble
   reg  [7:0]             fil_hi_q;
   reg  [7:0]             fil_hi_d;
   reg  [3:0]             fil_lo_q;
   reg  [3:0]             fil_lo_d;
   reg  [7:0]             msk_hi_q;
   reg  [7:0]             msk_hi_d;
   reg  [3:0]             msk_lo_q;
   reg  [3:0]             msk_lo_d;

   reg  [7:0]             rdata_d;
   reg                    store_d;
   reg                    discard_d;
   reg                    match_d;
   reg  [`CAF_ID_W-1:0]   store_id_d;
   reg                    store_rtr_d;

   wire [`CAF_CMP_W-1:0]  accept_value_bits;
   wire [`CAF_CMP_W-1:0]  accept_care_bits;
   wire [`CAF_CMP_W-1:0]  rx_bits;
   wire                   hit;
   wire                   is_std;
   wire                   is_ovld;
   wire                   frame_ok;
   wire                   accept;

   wire                   wr_fil_hi;
   wire                   wr_fil_lo;
   wire                   wr_msk_hi;
   wire                   wr_msk_lo;
   wire                   rd_fil_hi;
   wire                   rd_fil_lo;
   wire                   rd_msk_hi;
   wire                   rd_msk_lo;

   // full masked compare of 12 positions
   function match_f;
      input [`CAF_CMP_W-1:0] val;
      input [`CAF_CMP_W-1:0] care;
      input [`CAF_CMP_W-1:0] rx;
      begin
         match_f = (((val ^ rx) & care) == `CAF_CMP_ZERO);
      end
   endfunction

   // one strobe aimed at one register index
   function sel_f;
      input                   stb;
      input [`CAF_ADDR_W-1:0] addr;
      input [`CAF_ADDR_W-1:0] ofs;
      begin
         sel_f = stb & (addr == ofs);
      end
   endfunction

   // reserved low bits of a write are dropped, not stored
   function [3:0] lo_field_f;
      input [7:0] data;
      begin
         lo_field_f = data[`CAF_LO_FIELD_HI:`CAF_LO_FIELD_LO];
      end
   endfunction

   // reserved nibble always reads zero
   function [7:0] lo_read_f;
      input [3:0] nib;
      begin
         lo_read_f = {nib, `CAF_NIB_ZERO};
      end
   endfunction

   // frame kind decode
   function kind_is_f;
      input [1:0] kind;
      input [1:0] code;
      begin
         kind_is_f = (kind == code);
      end
   endfunction

   assign accept_value_bits = {fil_hi_q, fil_lo_q};
   assign accept_care_bits  = {msk_hi_q, msk_lo_q};
   assign rx_bits           = {frm_id_i, frm_rtr_i};
   assign hit               = match_f(accept_value_bits, accept_care_bits, rx_bits);
   assign is_std            = kind_is_f(frm_kind_i, `CAF_KIND_DATA);
   assign is_ovld           = kind_is_f(frm_kind_i, `CAF_KIND_OVLD);
   assign frame_ok          = frm_valid_i & frm_crc_ok_i;
   // extended frames never pass here, so they are never stored
   assign accept            = frame_ok & is_std & hit;

   assign wr_fil_hi = sel_f(wr_i, addr_i, `CAF_OFS_FIL_HI);
   assign wr_fil_lo = sel_f(wr_i, addr_i, `CAF_OFS_FIL_LO);
   assign wr_msk_hi = sel_f(wr_i, addr_i, `CAF_OFS_MSK_HI);
   assign wr_msk_lo = sel_f(wr_i, addr_i, `CAF_OFS_MSK_LO);
   assign rd_fil_hi = sel_f(rd_i, addr_i, `CAF_OFS_FIL_HI);
   assign rd_fil_lo = sel_f(rd_i, addr_i, `CAF_OFS_FIL_LO);
   assign rd_msk_hi = sel_f(rd_i, addr_i, `CAF_OFS_MSK_HI);
   assign rd_msk_lo = sel_f(rd_i, addr_i, `CAF_OFS_MSK_LO);

   // every well-formed frame except an overload frame is acknowledged, extended ones too
   assign ack_o      = frame_ok & ~is_ovld;
   // this node never starts an overload frame
   assign ovld_req_o = `CAF_BIT_ZERO;

   always @*
   begin
      fil_hi_d = fil_hi_q;
      if (wr_fil_hi)
      begin
         fil_hi_d = wdata_i;
      end
   end

   always @*
   begin
      fil_lo_d = fil_lo_q;
      if (wr_fil_lo)
      begin
         fil_lo_d = lo_field_f(wdata_i);
      end
   end

   always @*
   begin
      msk_hi_d = msk_hi_q;
      if (wr_msk_hi)
      begin
         msk_hi_d = wdata_i;
      end
   end

   always @*
   begin
      msk_lo_d = msk_lo_q;
      if (wr_msk_lo)
      begin
         msk_lo_d = lo_field_f(wdata_i);
      end
   end

   // undefined after reset in the device; zero keeps simulation known
   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fil_hi_q <= `CAF_BYTE_ZERO;
      end
      else
      begin
         fil_hi_q <= fil_hi_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fil_lo_q <= `CAF_NIB_ZERO;
      end
      else
      begin
         fil_lo_q <= fil_lo_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         msk_hi_q <= `CAF_BYTE_ZERO;
      end
      else
      begin
         msk_hi_q <= msk_hi_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         msk_lo_q <= `CAF_NIB_ZERO;
      end
      else
      begin
         msk_lo_q <= msk_lo_d;
      end
   end

   // read data stands only in the cycle after the strobe
   always @*
   begin
      rdata_d = `CAF_BYTE_ZERO;
      if (rd_fil_hi)
      begin
         rdata_d = fil_hi_q;
      end
      else if (rd_fil_lo)
      begin
         rdata_d = lo_read_f(fil_lo_q);
      end
      else if (rd_msk_hi)
      begin
         rdata_d = msk_hi_q;
      end
      else if (rd_msk_lo)
      begin
         rdata_d = lo_read_f(msk_lo_q);
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rdata_o <= `CAF_BYTE_ZERO;
      end
      else
      begin
         rdata_o <= rdata_d;
      end
   end

   // registered verdict, so each strobe is one clean pulse
   always @*
   begin
      store_d   = accept;
      discard_d = frm_valid_i & ~accept;
   end

   always @*
   begin
      match_d = match_q_o;
      if (frm_valid_i)
      begin
         match_d = hit;
      end
   end

   // stored identifier is held until the next accepted frame
   always @*
   begin
      store_id_d  = store_id_o;
      store_rtr_d = store_rtr_o;
      if (accept)
      begin
         store_id_d  = frm_id_i;
         store_rtr_d = frm_rtr_i;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         store_o <= `CAF_BIT_ZERO;
      end
      else
      begin
         store_o <= store_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         discard_o <= `CAF_BIT_ZERO;
      end
      else
      begin
         discard_o <= discard_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         match_q_o <= `CAF_BIT_ZERO;
      end
      else
      begin
         match_q_o <= match_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         store_id_o <= `CAF_ID_ZERO;
      end
      else
      begin
         store_id_o <= store_id_d;
      end
   end

   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         store_rtr_o <= `CAF_BIT_ZERO;
      end
      else
      begin
         store_rtr_o <= store_rtr_d;
      end
   end

endmodule

// ### sim/caf_props.sv
// checker on the acceptance filter ports
`timescale 1ns/1ns
module caf_props(input wire clock_i, rst_b_i, wr_i, rd_i, frm_valid_i, frm_rtr_i,
   frm_crc_ok_i, ack_o, ovld_req_o, store_o, store_rtr_o, discard_o, match_q_o,
   input wire [1:0] addr_i, frm_kind_i, input wire [7:0] wdata_i, rdata_o,
   input wire [10:0] frm_id_i, store_id_o);
default clocking @(posedge clock_i); endclocking
default disable iff (!rst_b_i);
property p_ovl; ovld_req_o == 1'b0; endproperty
a_ovl: assert property (p_ovl) else $error("overload raised");
property p_ext; frm_valid_i && frm_kind_i == 2'h1 |=> !store_o; endproperty
a_ext: assert property (p_ext) else $error("extended stored");
property p_ack; frm_valid_i && frm_crc_ok_i && frm_kind_i == 2'h1 |-> ack_o; endproperty
a_ack: assert property (p_ack) else $error("extended not acked");
property p_one; frm_valid_i |=> store_o ^ discard_o; endproperty
a_one: assert property (p_one) else $error("no verdict");
property p_sid; store_o |-> store_id_o == $past(frm_id_i) && match_q_o; endproperty
a_sid: assert property (p_sid) else $error("stored id");
property p_idl; !$past(frm_valid_i) |-> !store_o && !discard_o; endproperty
a_idl: assert property (p_idl) else $error("stray verdict");
property p_rd; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
a_rd: assert property (p_rd) else $error("stray read data");
property p_lo; $past(rd_i) && $past(addr_i[0]) |-> rdata_o[3:0] == 4'h0; endproperty
a_lo: assert property (p_lo) else $error("reserved bits");
cover property (store_o);
cover property (discard_o);
cover property (frm_valid_i && frm_kind_i == 2'h2);
endmodule
bind caf_filter caf_props i_props(.*);

// ### sim/caf_node.sv
// far-side node model presenting received frames
`timescale 1ns/1ns
module caf_node(input wire clock_i, output reg v_o, output reg [1:0] k_o,
   output reg [10:0] id_o, output reg rtr_o, output reg crc_o);
initial {v_o, k_o, id_o, rtr_o, crc_o} = 16'h0000;
task send(input [1:0] k, input [10:0] id, input r, input c);
   begin
      @(posedge clock_i);
      v_o <= 1'b1; k_o <= k; id_o <= id; rtr_o <= r; crc_o <= c;
      @(posedge clock_i);
      v_o <= 1'b0; k_o <= ~k; id_o <= ~id; rtr_o <= ~r; // released kind, id and rtr lines scrambled; crc line kept
   end
endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the acceptance filter
`timescale 1ns/1ns
module testbench;
reg clock_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, ack_l = 0;
reg [1:0] addr_i = 0; reg [7:0] wdata_i = 0; integer n_fail = 0, checks_done = 0;
wire fv, rtr, crc, ack_o, ovl, store_o, srtr, discard_o, mq;
wire [1:0] kind; wire [10:0] id, sid; wire [7:0] rdata_o;
initial forever #5 clock_i = ~clock_i;
caf_node i_node(.clock_i(clock_i), .v_o(fv), .k_o(kind), .id_o(id), .rtr_o(rtr), .crc_o(crc));
caf_filter i_dut(.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frm_valid_i(fv), .frm_kind_i(kind),
   .frm_id_i(id), .frm_rtr_i(rtr), .frm_crc_ok_i(crc), .ack_o(ack_o), .ovld_req_o(ovl),
   .store_o(store_o), .store_id_o(sid), .store_rtr_o(srtr), .discard_o(discard_o), .match_q_o(mq));
always @(posedge clock_i) if (fv) ack_l <= ack_o;
task chk(input string n, input [11:0] e, input [11:0] s);
   begin
      checks_done = checks_done + 1;
      if (s !== e) begin n_fail = n_fail + 1; $display("Error %s exp %h got %h", n, e, s); end
   end
endtask
task wr(input [1:0] a, input [7:0] d);
   begin @(posedge clock_i); addr_i <= a; wdata_i <= d; wr_i <= 1; @(posedge clock_i); wr_i <= 0; end
endtask
task rd(input [1:0] a, input [7:0] e);
   begin @(posedge clock_i); addr_i <= a; rd_i <= 1; @(posedge clock_i); rd_i <= 0; #1;
      chk("rdata", {4'h0, e}, {4'h0, rdata_o}); end
endtask
task frm(input [1:0] k, input [10:0] n, input r, input c, input [3:0] e);
   begin i_node.send(k, n, r, c); #1;
      chk("verdict", {8'h00, e}, {8'h00, mq, ack_l, store_o, discard_o});
      if (e[1]) chk("stored", {n, r}, {sid, srtr}); end
endtask
task t_regs;
   begin wr(0, 8'hA5); wr(1, 8'h30); wr(2, 8'h5A); wr(3, 8'hC0);
      rd(0, 8'hA5); rd(1, 8'h30); rd(2, 8'h5A); rd(3, 8'hC0); end
endtask
task t_match;
   begin wr(0, 8'hB4); wr(1, 8'h70); wr(2, 8'hFF); wr(3, 8'hF0);
      frm(0, 11'h5A3, 1, 1, 4'b1110);
      frm(0, 11'h5A3, 0, 1, 4'b0101);
      wr(3, 8'hE0); frm(0, 11'h5A3, 0, 1, 4'b1110);
      frm(0, 11'h5A2, 1, 1, 4'b0101); end
endtask
task t_scope;
   begin frm(1, 11'h5A3, 1, 1, 4'b1101);
      frm(2, 11'h5A3, 1, 1, 4'b1001); chk("ovl", 12'h000, {11'h000, ovl});
      frm(0, 11'h5A3, 1, 0, 4'b1001); end
endtask
task t_reset;
   begin @(posedge clock_i); rst_b_i <= 0; repeat (2) @(posedge clock_i); rst_b_i <= 1;
      rd(0, 8'h00); rd(3, 8'h00); end
endtask
task stop_test;
   begin $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish; end
endtask
initial begin repeat (20) @(posedge clock_i); rst_b_i <= 1; t_regs; t_match; t_scope; t_reset;
   stop_test; end
endmodule
